/* File: common/store_string_regs.vh */
// register map, field positions and codes for the store-string unit
// assumes byte addresses on a 32-bit axi4-lite register bus
`ifndef STORE_STRING_REGS_VH
`define STORE_STRING_REGS_VH
// =====================================================
// register byte offsets
`define REG_CTRL 8'h00
`define REG_ACC 8'h04
`define REG_DEST 8'h08
`define REG_COUNT 8'h0c
`define REG_SEG_BASE 8'h10
`define REG_SEG_LIMIT 8'h14
`define REG_SEG_ATTR 8'h18
`define REG_STATUS 8'h1c
`define REG_FLAGS 8'h20
// =====================================================
// control fields
`define CTRL_START 0
`define CTRL_WORD_OP 1
`define CTRL_OPSIZE32 2
`define CTRL_REPEAT 3
`define CTRL_DF 4
`define CTRL_OVERRIDE 5
`define CTRL_MODE_LO 6
`define CTRL_MODE_HI 7
`define CTRL_AC_EN 8
`define CTRL_CPL_LO 9
`define CTRL_CPL_HI 10
`define CTRL_MASK 32'h0000_07fe
// segment attribute fields
`define ATTR_WRITABLE 0
`define ATTR_NULL_SEL 1
`define ATTR_STACK 2
// =====================================================
// opcodes, modes, fault kinds
`define OPC_BYTE 8'haa
`define OPC_WORD 8'hab
`define MODE_REAL 2'h0
`define MODE_PROT 2'h1
`define MODE_V86 2'h2
`define FK_NONE 3'h0
`define FK_GP 3'h1
`define FK_SS 3'h2
`define FK_PF 3'h3
`define FK_AC 3'h4
`define CPL_USER 2'h3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* File: rtl/store_string_check.v */
// fault checks for one destination element of a store-string step
// assumes offset, limit and attributes are steady during the check
`timescale 1ns/1ps
`include "store_string_regs.vh"
module store_string_check (
    input wire [1:0] mode,
    input wire ac_en,
    input wire [1:0] cpl,
    input wire writable,
    input wire null_sel,
    input wire stack_seg,
    input wire [31:0] offset,
    input wire [31:0] limit,
    input wire [2:0] size,
    output reg [2:0] kind
);
    // =====================================================
    // limit and alignment
    wire [32:0] last = {1'b0, offset} + {30'h0, size} - 33'h0_0000_0001;
    wire over = last > {1'b0, limit};
    wire unaligned = (size == 3'h2) ? offset[0] : (size == 3'h4) ? (offset[1:0] != 2'h0) : 1'b0;
    always @* begin
        kind = `FK_NONE;
        case (mode)
            `MODE_PROT: begin
                if (!writable) begin
                    kind = `FK_GP;
                end else if (over || null_sel) begin
                    kind = `FK_GP;
                end else if (unaligned && ac_en && cpl == `CPL_USER) begin
                    kind = `FK_AC;
                end
            end
            `MODE_V86: begin
                if (over) begin
                    kind = stack_seg ? `FK_SS : `FK_GP;
                end else if (unaligned && ac_en) begin
                    kind = `FK_AC;
                end
            end
            default: begin
                if (over) begin
                    kind = stack_seg ? `FK_SS : `FK_GP;
                end
            end
        endcase
    end
endmodule

/* File: rtl/store_string_unit.v */
// store-string execution unit with an axi4-lite register slave
// assumes a memory port that answers each write with mem_ready
//
// Overview of operation
// - opcode aa stores the low accumulator byte, ab the 16 or 32 bit accumulator by operand size.
// - the destination is always extra segment plus destination index; an override prefix is ignored.
// - with 16-bit operand size only the 16-bit destination index addresses and steps.
// - after each store the index steps up when direction flag is 0 and down when it is 1.
// - the step is 1 for bytes, 2 for words and 4 for doublewords.
// - with a repeat prefix the store and step repeat once per element of the count register.
// - protected mode raises general protection with code 0 for a non-writable segment.
// - protected mode raises general protection with code 0 past the limit or on a null selector.
// - protected and virtual-8086 modes raise a page fault with its code when translation fails.
// - protected mode raises alignment check for unaligned stores only if enabled and privilege is 3.
// - virtual-8086 mode raises alignment check for any unaligned store when enabled.
// - real and virtual-8086 modes raise general protection past a segment limit, code 0 in v86.
// - real and virtual-8086 modes raise a stack fault past the stack segment limit.
//
// Implementation choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "store_string_regs.vh"
module store_string_unit (
    input wire clk,
    input wire rst_n,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg mem_valid,
    output reg [31:0] mem_addr,
    output reg [31:0] mem_wdata,
    output reg [2:0] mem_size,
    input wire mem_ready,
    input wire mem_page_fault,
    input wire [15:0] mem_fault_code
);
    // =====================================================
    // state
    localparam S_IDLE = 2'h0;
    localparam S_CHECK = 2'h1;
    localparam S_WRITE = 2'h2;
    localparam S_STEP = 2'h3;

    reg [1:0] state;
    reg [31:0] ctrl;
    reg [31:0] accumulator_32;
    reg [31:0] dest_index_32;
    reg [31:0] count_register;
    reg [31:0] seg_base;
    reg [31:0] seg_limit;
    reg [2:0] seg_attr;
    reg [31:0] flags_register;
    reg busy;
    reg done;
    reg [2:0] fault_kind;
    reg [15:0] error_code;
    reg [7:0] aw_addr;
    reg aw_held;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg w_held;

    // =====================================================
    // decoded control
    wire word_op = ctrl[`CTRL_WORD_OP];
    wire opsize32 = ctrl[`CTRL_OPSIZE32];
    wire repeat_prefix = ctrl[`CTRL_REPEAT];
    wire direction_flag = ctrl[`CTRL_DF];
    wire [1:0] mode = ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO];
    wire [7:0] opcode = word_op ? `OPC_WORD : `OPC_BYTE;
    wire store_string_byte = (opcode == `OPC_BYTE);
    wire store_string_dword = !store_string_byte && opsize32;
    wire [2:0] elem_size = store_string_byte ? 3'h1 : (store_string_dword ? 3'h4 : 3'h2);
    wire [15:0] dest_index_16 = dest_index_32[15:0];
    wire [31:0] eff_offset = opsize32 ? dest_index_32 : {16'h0, dest_index_16};
    wire [31:0] stepped = direction_flag ? dest_index_32 - {29'h0, elem_size}
                                         : dest_index_32 + {29'h0, elem_size};
    wire [31:0] next_dest = opsize32 ? stepped : {dest_index_32[31:16], stepped[15:0]};
    wire [31:0] next_count = opsize32 ? count_register - 32'h0000_0001
                                      : {count_register[31:16], count_register[15:0] - 16'h0001};
    wire count_zero = opsize32 ? (count_register == 32'h0000_0000) : (count_register[15:0] == 16'h0000);
    wire [2:0] check_kind;

    store_string_check u_check (
        .mode(mode),
        .ac_en(ctrl[`CTRL_AC_EN]),
        .cpl(ctrl[`CTRL_CPL_HI:`CTRL_CPL_LO]),
        .writable(seg_attr[`ATTR_WRITABLE]),
        .null_sel(seg_attr[`ATTR_NULL_SEL]),
        .stack_seg(seg_attr[`ATTR_STACK]),
        .offset(eff_offset),
        .limit(seg_limit),
        .size(elem_size),
        .kind(check_kind)
    );

    // =====================================================
    // store data by element size
    reg [31:0] store_data;
    always @* begin
        if (store_string_byte) begin
            store_data = {24'h0, accumulator_32[7:0]};
        end else if (store_string_dword) begin
            store_data = accumulator_32;
        end else begin
            store_data = {16'h0, accumulator_32[15:0]};
        end
    end

    // =====================================================
    // register write path
    wire wr_fire = aw_held && w_held && !s_axi_bvalid;
    wire idle_write = wr_fire && !busy;
    wire wr_hit = (aw_addr == `REG_CTRL) || (aw_addr == `REG_ACC) || (aw_addr == `REG_DEST)
                  || (aw_addr == `REG_COUNT) || (aw_addr == `REG_SEG_BASE) || (aw_addr == `REG_SEG_LIMIT)
                  || (aw_addr == `REG_SEG_ATTR) || (aw_addr == `REG_STATUS) || (aw_addr == `REG_FLAGS);
    wire start_req = idle_write && (aw_addr == `REG_CTRL) && w_strb[0] && w_data[`CTRL_START];

    function [31:0] merge;
        input [31:0] old;
        input [31:0] data;
        input [3:0] strb;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    merge[i*8 +: 8] = data[i*8 +: 8];
                end
            end
        end
    endfunction

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready;
            s_axi_wready <= !w_held && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // =====================================================
    // register read path
    reg [31:0] rd_mux;
    reg rd_hit;
    always @* begin
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `REG_CTRL: rd_mux = ctrl;
            `REG_ACC: rd_mux = accumulator_32;
            `REG_DEST: rd_mux = dest_index_32;
            `REG_COUNT: rd_mux = count_register;
            `REG_SEG_BASE: rd_mux = seg_base;
            `REG_SEG_LIMIT: rd_mux = seg_limit;
            `REG_SEG_ATTR: rd_mux = {29'h0, seg_attr};
            `REG_STATUS: rd_mux = {error_code, 10'h0, fault_kind, done, busy, 1'b0};
            `REG_FLAGS: rd_mux = flags_register;
            default: begin
                rd_mux = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // =====================================================
    // sequencer and architectural registers
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= S_IDLE;
            ctrl <= 32'h0000_0000;
            accumulator_32 <= 32'h0000_0000;
            dest_index_32 <= 32'h0000_0000;
            count_register <= 32'h0000_0000;
            seg_base <= 32'h0000_0000;
            seg_limit <= 32'h0000_ffff;
            seg_attr <= 3'h1;
            flags_register <= 32'h0000_0000;
            busy <= 1'b0;
            done <= 1'b0;
            fault_kind <= `FK_NONE;
            error_code <= 16'h0000;
            mem_valid <= 1'b0;
            mem_addr <= 32'h0000_0000;
            mem_wdata <= 32'h0000_0000;
            mem_size <= 3'h0;
        end else begin
            if (idle_write) begin
                case (aw_addr)
                    `REG_CTRL: ctrl <= merge(ctrl, w_data, w_strb) & `CTRL_MASK;
                    `REG_ACC: accumulator_32 <= merge(accumulator_32, w_data, w_strb);
                    `REG_DEST: dest_index_32 <= merge(dest_index_32, w_data, w_strb);
                    `REG_COUNT: count_register <= merge(count_register, w_data, w_strb);
                    `REG_SEG_BASE: seg_base <= merge(seg_base, w_data, w_strb);
                    `REG_SEG_LIMIT: seg_limit <= merge(seg_limit, w_data, w_strb);
                    `REG_SEG_ATTR: seg_attr <= w_strb[0] ? w_data[2:0] : seg_attr;
                    `REG_STATUS: begin
                        if (w_strb[0] && w_data[1]) begin
                            done <= 1'b0;
                            fault_kind <= `FK_NONE;
                            error_code <= 16'h0000;
                        end
                    end
                    // flags are only ever loaded by software, never by a store
                    `REG_FLAGS: flags_register <= merge(flags_register, w_data, w_strb);
                    default: begin
                    end
                endcase
            end
            case (state)
                S_IDLE: begin
                    if (start_req) begin
                        busy <= 1'b1;
                        done <= 1'b0;
                        fault_kind <= `FK_NONE;
                        error_code <= 16'h0000;
                        state <= S_CHECK;
                    end
                end
                S_CHECK: begin
                    // zero count is judged here, once the new control word has landed
                    if (repeat_prefix && count_zero) begin
                        busy <= 1'b0;
                        done <= 1'b1;
                        state <= S_IDLE;
                    end else if (check_kind != `FK_NONE) begin
                        fault_kind <= check_kind;
                        error_code <= 16'h0000;
                        busy <= 1'b0;
                        done <= 1'b1;
                        state <= S_IDLE;
                    end else begin
                        mem_valid <= 1'b1;
                        mem_addr <= seg_base + eff_offset;
                        mem_wdata <= store_data;
                        mem_size <= elem_size;
                        state <= S_WRITE;
                    end
                end
                S_WRITE: begin
                    if (mem_ready) begin
                        mem_valid <= 1'b0;
                        if (mem_page_fault && mode != `MODE_REAL) begin
                            fault_kind <= `FK_PF;
                            error_code <= mem_fault_code;
                            busy <= 1'b0;
                            done <= 1'b1;
                            state <= S_IDLE;
                        end else begin
                            state <= S_STEP;
                        end
                    end
                end
                S_STEP: begin
                    dest_index_32 <= next_dest;
                    if (repeat_prefix) begin
                        count_register <= next_count;
                        if (next_count == 32'h0000_0000 || (!opsize32 && next_count[15:0] == 16'h0000)) begin
                            busy <= 1'b0;
                            done <= 1'b1;
                            state <= S_IDLE;
                        end else begin
                            state <= S_CHECK;
                        end
                    end else begin
                        busy <= 1'b0;
                        done <= 1'b1;
                        state <= S_IDLE;
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end
endmodule

/* File: tb/mem_model.sv */
// memory-side partner of the store-string unit
// assumes the bench sets the answer delay and the faulting address
`timescale 1ns/1ps
module mem_model #(
    parameter [15:0] FAULT_CODE = 16'h00a6
) (
    input wire clk,
    input wire rst_n,
    input wire mem_valid,
    input wire [31:0] mem_addr,
    input wire [3:0] wait_cyc,
    input wire [31:0] pf_addr,
    input wire pf_en,
    output logic mem_ready,
    output logic mem_page_fault,
    output logic [15:0] mem_fault_code
);
    logic [3:0] cnt;
    // ==========================================
    // answer after wait_cyc cycles; fault lines churn outside answers
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_ready <= 1'b0;
            mem_page_fault <= 1'b0;
            mem_fault_code <= 16'h0000;
            cnt <= 4'h0;
        end else if (mem_valid && !mem_ready && cnt >= wait_cyc) begin
            mem_ready <= 1'b1;
            mem_page_fault <= pf_en && mem_addr == pf_addr;
            mem_fault_code <= FAULT_CODE;
            cnt <= 4'h0;
        end else begin
            mem_ready <= 1'b0;
            mem_page_fault <= ~mem_page_fault;
            mem_fault_code <= ~mem_fault_code;
            cnt <= mem_valid ? cnt + 4'h1 : 4'h0;
        end
    end
endmodule

/* File: tb/store_string_asserts.sv */
// port assertions for the store-string unit
// assumes it is bound into store_string_unit by the statement at the foot
`timescale 1ns/1ps
module store_string_asserts (
    input logic clk,
    input logic rst_n,
    input logic s_axi_awvalid,
    input logic s_axi_awready,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic [1:0] s_axi_bresp,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    input logic [31:0] s_axi_rdata,
    input logic mem_valid,
    input logic mem_ready,
    input logic [31:0] mem_addr,
    input logic [31:0] mem_wdata,
    input logic [2:0] mem_size
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ==========================================
    // store port
    a_size_legal: assert property (mem_valid |-> mem_size == 3'h1 || mem_size == 3'h2 || mem_size == 3'h4)
        else $error("store size not 1, 2 or 4");
    a_byte_zero: assert property (mem_valid && mem_size == 3'h1 |-> mem_wdata[31:8] == 24'h00_0000)
        else $error("byte store carries upper bits");
    a_word_zero: assert property (mem_valid && mem_size == 3'h2 |-> mem_wdata[31:16] == 16'h0000)
        else $error("word store carries upper bits");
    a_store_hold: assert property (mem_valid && !mem_ready |=> mem_valid && $stable(mem_addr) && $stable(mem_wdata))
        else $error("store dropped or changed while waiting");
    a_store_gap: assert property (mem_valid && mem_ready |=> !mem_valid [*2])
        else $error("next store too soon after previous");
    // ==========================================
    // register bus
    a_aw_once: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("write address ready not lowered after take");
    a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
    c_dword: cover property (mem_valid && mem_ready && mem_size == 3'h4);
    c_slow: cover property (mem_valid && !mem_ready ##1 mem_ready);
    c_resp: cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind store_string_unit store_string_asserts u_chk (.*);

/* File: tb/tb.sv */
// self-checking bench for the store-string unit
// assumes mem_model answers the store port
`timescale 1ns/1ps
`include "store_string_regs.vh"
module tb;
    localparam logic [15:0] PF_CODE = 16'h00a6;
    localparam logic [31:0] BASE = 32'h1000_0000;
    localparam logic [31:0] BIG = 32'h000f_ffff;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'h0, wait_cyc = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, pf_en = 1'b0;
    logic [31:0] pf_addr = 32'h0000_0000, seed = 32'hc2b0_b2af, v, flg;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire mem_valid, mem_ready, mem_page_fault;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata, mem_addr, mem_wdata;
    wire [2:0] mem_size;
    wire [15:0] mem_fault_code;
    int num_errors = 0, checks = 0, cyc = 0;
    logic [66:0] exp_st[$], se;
    logic [65:0] exp_rd[$], re;
    logic [1:0] exp_b[$];
    logic [31:0] rst_val [9] = '{0, 0, 0, 0, 0, 32'h0000_ffff, 1, 0, 0};
    store_string_unit i_dut (.*);
    mem_model #(.FAULT_CODE(PF_CODE)) i_mem (.*);
    always #10 clk = ~clk;
    // ==========================================
    // checks and bus tasks
    task automatic chk(input string n, input logic [66:0] e, input logic [66:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic print_verdict;
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wr(input [7:0] a, input [31:0] d, input [3:0] s, input [1:0] r);
        bit ad, wd;
        ad = 0;
        wd = 0;
        exp_b.push_back(r);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge clk);
            if (!ad && s_axi_awready) begin
                ad = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (!wd && s_axi_wready) begin
                wd = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        repeat (2) @(posedge clk);
        s_axi_bready <= 1'b1;
        do @(posedge clk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input [7:0] a, input [31:0] m, input [31:0] e, input [1:0] r, output [31:0] d);
        exp_rd.push_back({m, e, r});
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        @(posedge clk);
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
    endtask
    function automatic [31:0] cw(input w, o, rp, df, ov, input [1:0] md, input ac, input [1:0] cpl);
        cw = {21'h0, cpl, ac, md, ov, df, rp, o, w, 1'b0};
    endfunction
    // one operation: predict stores, start, wait done, check status and indexes
    task automatic run(input [31:0] c, at, lim, d, n, input int nst, input [2:0] fk);
        logic [31:0] acc, st, cnt;
        int sz, dl, de;
        acc = $random(seed);
        sz = !c[`CTRL_WORD_OP] ? 1 : c[`CTRL_OPSIZE32] ? 4 : 2;
        dl = c[`CTRL_DF] ? -sz : sz;
        de = fk == `FK_PF ? nst - 1 : nst;
        wait_cyc <= 4'($random(seed) & 3);
        wr(`REG_SEG_ATTR, at, 4'hf, `RESP_OKAY);
        wr(`REG_SEG_LIMIT, lim, 4'hf, `RESP_OKAY);
        wr(`REG_ACC, acc, 4'hf, `RESP_OKAY);
        wr(`REG_DEST, d, 4'hf, `RESP_OKAY);
        wr(`REG_COUNT, n, 4'hf, `RESP_OKAY);
        for (int i = 0; i < nst; i++) begin
            exp_st.push_back({BASE + (c[`CTRL_OPSIZE32] ? d : {16'h0000, d[15:0]}),
                acc & 32'((64'h1 << (8 * sz)) - 1), 3'(sz)});
            if (i < de)
                d = c[`CTRL_OPSIZE32] ? d + dl : {d[31:16], d[15:0] + 16'(dl)};
        end
        cnt = !c[`CTRL_REPEAT] ? n : c[`CTRL_OPSIZE32] ? n - de : {n[31:16], n[15:0] - 16'(de)};
        wr(`REG_CTRL, c | 32'h0000_0001, 4'hf, `RESP_OKAY);
        st = 32'h0000_0000;
        for (int k = 0; k < 100 && !st[2]; k++) rd(`REG_STATUS, 0, 0, `RESP_OKAY, st);
        rd(`REG_STATUS, 32'hffff_ffff, {fk == `FK_PF ? PF_CODE : 16'h0000, 10'h000, fk, 3'h4}, `RESP_OKAY, st);
        rd(`REG_DEST, 32'hffff_ffff, d, `RESP_OKAY, st);
        rd(`REG_COUNT, 32'hffff_ffff, cnt, `RESP_OKAY, st);
        wr(`REG_STATUS, 32'h0000_0002, 4'hf, `RESP_OKAY);
    endtask
    // ==========================================
    // result watcher and hang limit
    always @(posedge clk) begin
        if (rst_n && mem_valid && mem_ready) begin
            se = exp_st.size() ? exp_st.pop_front() : 67'h0;
            chk("store", se, {mem_addr, mem_wdata, mem_size});
        end
        if (rst_n && s_axi_rvalid && s_axi_rready) begin
            re = exp_rd.pop_front();
            chk("read", {re[65:34] & re[33:2], re[1:0]}, {re[65:34] & s_axi_rdata, s_axi_rresp});
        end
        if (rst_n && s_axi_bvalid && s_axi_bready)
            chk("bresp", exp_b.pop_front(), s_axi_bresp);
        cyc++;
        if (cyc == 40000) begin
            num_errors++;
            print_verdict();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
    end
    // ==========================================
    // main sequence
    initial begin
        @(posedge rst_n);
        for (int i = 0; i < 9; i++) rd(8'(4 * i), 32'hffff_ffff, rst_val[i], `RESP_OKAY, v);
        rd(8'h24, 32'hffff_ffff, 0, `RESP_SLVERR, v);
        wr(8'h24, 32'h0000_0001, 4'hf, `RESP_SLVERR);
        wr(`REG_ACC, 32'hffff_ffff, 4'hf, `RESP_OKAY);
        wr(`REG_ACC, 32'h0000_aa00, 4'h2, `RESP_OKAY);
        rd(`REG_ACC, 32'hffff_ffff, 32'hffff_aaff, `RESP_OKAY, v);
        v = $random(seed) & 32'hffff_fffe;
        wr(`REG_CTRL, v, 4'hf, `RESP_OKAY);
        rd(`REG_CTRL, 32'hffff_ffff, v & `CTRL_MASK, `RESP_OKAY, v);
        flg = $random(seed);
        wr(`REG_FLAGS, flg, 4'hf, `RESP_OKAY);
        wr(`REG_SEG_BASE, BASE, 4'hf, `RESP_OKAY);
        run(cw(0, 1, 0, 0, 0, 2'h0, 0, 0), 1, BIG, 16'h0010, 1, 1, 3'h0);
        run(cw(1, 0, 1, 1, 0, 2'h0, 0, 0), 1, BIG, 32'h0003_0002, 3, 3, 3'h0);
        run(cw(1, 1, 1, 0, 1, 2'h1, 0, 0), 1, BIG, 16'h0100, 4, 4, 3'h0);
        run(cw(1, 1, 1, 1, 0, 2'h2, 0, 0), 1, BIG, 16'h0200, 2, 2, 3'h0);
        run(cw(0, 1, 1, 0, 0, 2'h0, 0, 0), 1, BIG, 16'h0300, 0, 0, 3'h0);
        run(cw(1, 1, 0, 0, 0, 2'h1, 0, 0), 0, BIG, 16'h0010, 1, 0, 3'h1);
        run(cw(1, 1, 0, 0, 0, 2'h1, 0, 0), 3, BIG, 16'h0010, 1, 0, 3'h1);
        run(cw(1, 1, 0, 0, 0, 2'h1, 0, 0), 1, 16'h00ff, 16'h00fc, 1, 1, 3'h0);
        run(cw(1, 1, 0, 0, 0, 2'h1, 0, 0), 1, 16'h0100, 16'h00fe, 1, 0, 3'h1);
        run(cw(1, 1, 0, 0, 0, 2'h0, 0, 0), 1, 16'h0100, 16'h00fe, 1, 0, 3'h1);
        run(cw(1, 1, 0, 0, 0, 2'h2, 0, 0), 1, 16'h0100, 16'h00fe, 1, 0, 3'h1);
        run(cw(1, 1, 0, 0, 0, 2'h0, 0, 0), 5, 16'h0100, 16'h00fe, 1, 0, 3'h2);
        run(cw(1, 1, 0, 0, 0, 2'h2, 0, 0), 5, 16'h0100, 16'h00fe, 1, 0, 3'h2);
        pf_addr <= BASE + 32'h0000_0040;
        pf_en <= 1'b1;
        run(cw(1, 1, 1, 0, 0, 2'h1, 0, 0), 1, BIG, 16'h0038, 3, 3, 3'h3);
        run(cw(1, 1, 1, 0, 0, 2'h2, 0, 0), 1, BIG, 16'h0038, 3, 3, 3'h3);
        run(cw(1, 1, 1, 0, 0, 2'h0, 0, 0), 1, BIG, 16'h0038, 3, 3, 3'h0);
        pf_en <= 1'b0;
        run(cw(1, 1, 0, 0, 0, 2'h1, 1, 3), 1, BIG, 16'h0001, 1, 0, 3'h4);
        run(cw(1, 1, 0, 0, 0, 2'h1, 1, 0), 1, BIG, 16'h0001, 1, 1, 3'h0);
        run(cw(1, 1, 0, 0, 0, 2'h1, 0, 3), 1, BIG, 16'h0001, 1, 1, 3'h0);
        run(cw(1, 0, 0, 0, 0, 2'h2, 1, 0), 1, BIG, 16'h0001, 1, 0, 3'h4);
        run(cw(1, 1, 0, 0, 0, 2'h2, 0, 0), 1, BIG, 16'h0001, 1, 1, 3'h0);
        rd(`REG_FLAGS, 32'hffff_ffff, flg, `RESP_OKAY, v);
        chk("pending", 0, exp_st.size());
        print_verdict();
    end
endmodule
